// ==== hw/qha_pkg.sv ====
// Constants shared by the queue host access design
package qha_pkg;

	// =====================================================
	// Widths
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int PTR_W = 7;
	localparam int MODE_W = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W = DATA_W + 1;
	localparam int LEVEL_W = $clog2(FIFO_DEPTH) + 1;

	// =====================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_TX_DATA = 10'h00c;
	localparam logic [ADDR_W-1:0] OFS_RX_DATA = 10'h010;
	localparam logic [ADDR_W-1:0] OFS_PTRS = 10'h018;
	localparam logic [ADDR_W-1:0] OFS_STATE = 10'h01c;
	localparam logic [ADDR_W-1:0] OFS_DMA = 10'h100;
	localparam logic [ADDR_W-1:0] OFS_RX_PKT = 10'h104;

	// =====================================================
	// Field positions
	localparam int PTR_LAST_LSB = 16;
	localparam int PTR_FIRST_LSB = 0;
	localparam int ST_READY_BIT = 31;
	localparam int ST_PMASK_BIT = 30;
	localparam int ST_MODE_LSB = 24;
	localparam int ST_EOP_BIT = 18;
	localparam int ST_ABOVE_BIT = 17;
	localparam int ST_BELOW_BIT = 16;
	localparam int ST_THR_LSB = 8;
	localparam int ST_COUNT_LSB = 0;
	localparam int DMA_RD_BIT = 17;
	localparam int DMA_WR_BIT = 16;
	localparam int DMA_ADDR_LSB = 0;
	localparam int RXP_DONE_BIT = 31;

	// =====================================================
	// Reset values
	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
	localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
	localparam int STATIC_Q_A = 2;
	localparam int STATIC_Q_B = 5;
	localparam logic [PTR_W-1:0] STATIC_A_FIRST = 7'h01;
	localparam logic [PTR_W-1:0] STATIC_A_LAST = 7'h01;
	localparam logic [PTR_W-1:0] STATIC_B_FIRST = 7'h02;
	localparam logic [PTR_W-1:0] STATIC_B_LAST = 7'h02;

	// =====================================================
	// Data-ready modes
	typedef enum logic [MODE_W-1:0] {
		QHA_MODE_FIRST = 2'h0,
		QHA_MODE_ABOVE = 2'h1,
		QHA_MODE_LAST_PACKET_END_POINTER = 2'h2,
		QHA_MODE_EITHER = 2'h3
	} qha_mode_t;

endpackage : qha_pkg

// ==== hw/qha_fifo.sv ====
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps

module qha_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] level_reg;
	logic push;
	logic pop;

	assign in_ready_o = (level_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (level_reg != '0);
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem[rd_ptr_reg];
	assign level_o = level_reg;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			level_reg <= level_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : qha_fifo

// ==== hw/qha_ready_eval.sv ====
// Threshold compare and data-ready condition for one queue
`timescale 1ns/1ps

module qha_ready_eval (
	input wire logic [6:0] count_i,
	input wire logic [6:0] thr_i,
	input wire qha_pkg::qha_mode_t mode_i,
	input wire logic first_nz_i,
	input wire logic last_packet_end_pointer_nz_i,
	input wire logic pause_i,
	input wire logic pmask_i,
	output logic above_o,
	output logic below_o,
	output logic set_o
);
	import qha_pkg::*;

	logic cond;
	logic blocked;

	// Equal count leaves both flags low
	assign above_o = (count_i > thr_i);
	assign below_o = (count_i < thr_i);

	// Mode selects the data-ready source
	assign cond = (mode_i == QHA_MODE_FIRST) ? first_nz_i :
		(mode_i == QHA_MODE_ABOVE) ? above_o :
		(mode_i == QHA_MODE_LAST_PACKET_END_POINTER) ? last_packet_end_pointer_nz_i :
		(above_o | last_packet_end_pointer_nz_i);

	// Pause only holds off the flag when the mask is clear
	assign blocked = pause_i & ~pmask_i;
	assign set_o = cond & ~blocked;

endmodule : qha_ready_eval

// ==== hw/qha_queue_regs.sv ====
// Per-queue host access registers with data queue and DMA steering
`timescale 1ns/1ps
// =====================================================
// Functional notes
// - Host write appends full word to queue
// - Host read pops and returns queue head
// - Last pointer in bits 22:16, read/write
// - First pointer in bits 6:0, read/write
// - Static queues reset pointers to nonzero defaults
// - Mode field selects data-ready set condition
// - Pause blocks data-ready unless mask set
// - End-of-packet bit shows marker in queue
// - Count compared with threshold, above and below
// - Count field reports blocks held by queue
// - Static queues report only bits 31:30 of the status word
// - Read mode holds until host write clears
// - Write mode holds until host read clears
// - Address field steers all DMA-mode accesses
// - Packet status register done flag at 0x104

module qha_queue_regs #(
	parameter int QUEUE_NUM = 0
) (
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	input wire logic [qha_pkg::ADDR_W-1:0] HOST_ADDR_I,
	input wire logic HOST_WR_I,
	input wire logic HOST_RD_I,
	input wire logic [qha_pkg::DATA_W-1:0] HOST_WDATA_I,
	input wire logic HOST_EOP_I,
	input wire logic PAUSE_I,
	output logic [qha_pkg::DATA_W-1:0] HOST_RDATA_O,
	output logic HOST_RVALID_O,
	output logic TX_READY_O,
	output logic QUEUE_READY_O,
	output logic DMA_READ_MODE_O,
	output logic DMA_WRITE_MODE_O
);
	import qha_pkg::*;

	// =====================================================
	// Reset values that depend on the queue number
	localparam logic IS_STATIC =
		(QUEUE_NUM == STATIC_Q_A) || (QUEUE_NUM == STATIC_Q_B);
	localparam logic [PTR_W-1:0] FIRST_RST =
		(QUEUE_NUM == STATIC_Q_A) ? STATIC_A_FIRST :
		(QUEUE_NUM == STATIC_Q_B) ? STATIC_B_FIRST : PTR_RESET;
	localparam logic [PTR_W-1:0] LAST_RST =
		(QUEUE_NUM == STATIC_Q_A) ? STATIC_A_LAST :
		(QUEUE_NUM == STATIC_Q_B) ? STATIC_B_LAST : PTR_RESET;

	// =====================================================
	// Registers
	logic [PTR_W-1:0] first_reg;
	logic [PTR_W-1:0] first_next;
	logic [PTR_W-1:0] last_reg;
	logic [PTR_W-1:0] last_next;
	logic [PTR_W-1:0] thr_reg;
	logic [PTR_W-1:0] thr_next;
	qha_mode_t mode_reg;
	qha_mode_t mode_next;
	logic pmask_reg;
	logic pmask_next;
	logic qdr_reg;
	logic qdr_next;
	logic dma_rd_reg;
	logic dma_rd_next;
	logic dma_wr_reg;
	logic dma_wr_next;
	logic [ADDR_W-1:0] dma_addr_reg;
	logic [ADDR_W-1:0] dma_addr_next;
	logic [LEVEL_W-1:0] eop_cnt_reg;
	logic [LEVEL_W-1:0] eop_cnt_next;
	logic [DATA_W-1:0] rdata_reg;
	logic rvalid_reg;

	// =====================================================
	// Address steering and decode
	logic [ADDR_W-1:0] wr_addr;
	logic [ADDR_W-1:0] rd_addr;
	logic wr_tx;
	logic wr_ptrs;
	logic wr_state;
	logic wr_dma;
	logic rd_rx;
	logic rd_dma;

	// In DMA mode every access of that direction lands on one address
	assign wr_addr = dma_wr_reg ? dma_addr_reg : HOST_ADDR_I;
	assign rd_addr = dma_rd_reg ? dma_addr_reg : HOST_ADDR_I;
	assign wr_tx = HOST_WR_I & (wr_addr == OFS_TX_DATA);
	assign wr_ptrs = HOST_WR_I & (wr_addr == OFS_PTRS);
	assign wr_state = HOST_WR_I & (wr_addr == OFS_STATE);
	assign wr_dma = HOST_WR_I & (wr_addr == OFS_DMA);
	assign rd_rx = HOST_RD_I & (rd_addr == OFS_RX_DATA);
	assign rd_dma = HOST_RD_I & (rd_addr == OFS_DMA);

	// =====================================================
	// Data queue
	logic push;
	logic pop;
	logic in_ready;
	logic out_valid;
	logic [FIFO_W-1:0] head;
	logic [LEVEL_W-1:0] level;
	logic head_eop;

	// A full queue drops the write; software watches the ready output
	assign push = wr_tx & in_ready;
	// Reading an empty queue pops nothing and returns zero
	assign pop = rd_rx & out_valid;
	assign head_eop = head[FIFO_W-1];
	assign TX_READY_O = in_ready;

	qha_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(CLOCK_I),
		.rstn_i(RSTN_I),
		.in_valid_i(wr_tx),
		.in_ready_o(in_ready),
		.in_data_i({HOST_EOP_I, HOST_WDATA_I}),
		.out_valid_o(out_valid),
		.out_ready_i(rd_rx),
		.out_data_o(head),
		.level_o(level)
	);

	// =====================================================
	// End-of-packet tracking and count
	logic eop_present;
	logic [PTR_W-1:0] count;

	assign eop_cnt_next = eop_cnt_reg
		+ LEVEL_W'(push & HOST_EOP_I)
		- LEVEL_W'(pop & head_eop);
	assign eop_present = (eop_cnt_reg != '0);
	// One word per block in this queue
	assign count = PTR_W'(level);

	// =====================================================
	// Status evaluation
	logic above;
	logic below;
	logic ready_set;

	qha_ready_eval u_eval (
		.count_i(count),
		.thr_i(thr_reg),
		.mode_i(mode_reg),
		.first_nz_i(first_reg != PTR_RESET),
		.last_packet_end_pointer_nz_i(eop_present),
		.pause_i(PAUSE_I),
		.pmask_i(pmask_reg),
		.above_o(above),
		.below_o(below),
		.set_o(ready_set)
	);

	// =====================================================
	// Register next values
	assign first_next = wr_ptrs ?
		HOST_WDATA_I[PTR_FIRST_LSB +: PTR_W] : first_reg;
	assign last_next = wr_ptrs ?
		HOST_WDATA_I[PTR_LAST_LSB +: PTR_W] : last_reg;
	assign thr_next = wr_state ?
		HOST_WDATA_I[ST_THR_LSB +: PTR_W] : thr_reg;
	assign mode_next = wr_state ?
		qha_mode_t'(HOST_WDATA_I[ST_MODE_LSB +: MODE_W]) : mode_reg;
	assign pmask_next = wr_state ?
		HOST_WDATA_I[ST_PMASK_BIT] : pmask_reg;
	// Hardware set wins over a clearing write in the same cycle
	assign qdr_next = ready_set |
		(wr_state ? HOST_WDATA_I[ST_READY_BIT] : qdr_reg);
	assign dma_rd_next = wr_dma ?
		HOST_WDATA_I[DMA_RD_BIT] : dma_rd_reg;
	// A write that sets the bit beats a read clearing it
	assign dma_wr_next = wr_dma ? HOST_WDATA_I[DMA_WR_BIT] :
		(rd_dma ? 1'b0 : dma_wr_reg);
	assign dma_addr_next = wr_dma ?
		HOST_WDATA_I[DMA_ADDR_LSB +: ADDR_W] : dma_addr_reg;

	// =====================================================
	// Read data selection
	logic [DATA_W-1:0] ptr_word;
	logic [DATA_W-1:0] state_word;
	logic [DATA_W-1:0] dma_word;
	logic [DATA_W-1:0] rxp_word;
	logic [DATA_W-1:0] rd_word;

	always_comb begin
		ptr_word = REG_RESET;
		ptr_word[PTR_FIRST_LSB +: PTR_W] = first_reg;
		ptr_word[PTR_LAST_LSB +: PTR_W] = last_reg;
		state_word = REG_RESET;
		state_word[ST_READY_BIT] = qdr_reg;
		state_word[ST_PMASK_BIT] = pmask_reg;
		// Static queues keep only the two top bits meaningful
		if (!IS_STATIC) begin
			state_word[ST_MODE_LSB +: MODE_W] = mode_reg;
			state_word[ST_EOP_BIT] = eop_present;
			state_word[ST_ABOVE_BIT] = above;
			state_word[ST_BELOW_BIT] = below;
			state_word[ST_THR_LSB +: PTR_W] = thr_reg;
			state_word[ST_COUNT_LSB +: PTR_W] = count;
		end
		dma_word = REG_RESET;
		dma_word[DMA_RD_BIT] = dma_rd_reg;
		dma_word[DMA_WR_BIT] = dma_wr_reg;
		dma_word[DMA_ADDR_LSB +: ADDR_W] = dma_addr_reg;
		rxp_word = REG_RESET;
		// Done means an end-of-packet word sits in the queue
		rxp_word[RXP_DONE_BIT] = eop_present;
	end

	// Transmit port reads as zero, as do unmapped offsets
	assign rd_word =
		(rd_addr == OFS_RX_DATA) ?
			(out_valid ? head[DATA_W-1:0] : REG_RESET) :
		(rd_addr == OFS_PTRS) ? ptr_word :
		(rd_addr == OFS_STATE) ? state_word :
		(rd_addr == OFS_DMA) ? dma_word :
		(rd_addr == OFS_RX_PKT) ? rxp_word : REG_RESET;

	// =====================================================
	// Flip-flops
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			first_reg <= FIRST_RST;
			last_reg <= LAST_RST;
			thr_reg <= PTR_RESET;
			mode_reg <= QHA_MODE_FIRST;
			pmask_reg <= 1'b0;
			qdr_reg <= 1'b0;
		end else begin
			first_reg <= first_next;
			last_reg <= last_next;
			thr_reg <= thr_next;
			mode_reg <= mode_next;
			pmask_reg <= pmask_next;
			qdr_reg <= qdr_next;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			dma_rd_reg <= 1'b0;
			dma_wr_reg <= 1'b0;
			dma_addr_reg <= '0;
			eop_cnt_reg <= '0;
		end else begin
			dma_rd_reg <= dma_rd_next;
			dma_wr_reg <= dma_wr_next;
			dma_addr_reg <= dma_addr_next;
			eop_cnt_reg <= eop_cnt_next;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rdata_reg <= REG_RESET;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= HOST_RD_I ? rd_word : rdata_reg;
			rvalid_reg <= HOST_RD_I;
		end
	end

	assign HOST_RDATA_O = rdata_reg;
	assign HOST_RVALID_O = rvalid_reg;
	assign QUEUE_READY_O = qdr_reg;
	assign DMA_READ_MODE_O = dma_rd_reg;
	assign DMA_WRITE_MODE_O = dma_wr_reg;

	// =====================================================
	// Assertions
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RSTN_I);

	sequence dma_wr_on_s;
		dma_wr_reg && !wr_dma;
	endsequence

	sequence dma_read_s;
		rd_dma && !wr_dma;
	endsequence

	push_grows_a: assert property (
		push && !pop |=> level == $past(level) + LEVEL_W'(1))
		else $error("push did not grow queue");

	pop_returns_a: assert property (
		pop |=> HOST_RVALID_O && HOST_RDATA_O == $past(head[DATA_W-1:0]))
		else $error("pop returned wrong word");

	ptr_last_wr_a: assert property (
		wr_ptrs |=> last_reg == $past(HOST_WDATA_I[PTR_LAST_LSB +: PTR_W]))
		else $error("last pointer not written");

	ptr_first_wr_a: assert property (
		wr_ptrs |=> first_reg == $past(HOST_WDATA_I[PTR_FIRST_LSB +: PTR_W]))
		else $error("first pointer not written");

	ready_first_a: assert property (
		mode_reg == QHA_MODE_FIRST && first_reg != PTR_RESET && !PAUSE_I
		|=> qdr_reg)
		else $error("data-ready not set");

	pause_hold_a: assert property (
		PAUSE_I && !pmask_reg && !qdr_reg && !wr_state |=> !qdr_reg)
		else $error("pause did not block data-ready");

	eop_read_a: assert property (
		HOST_RD_I && rd_addr == OFS_STATE && !IS_STATIC
		|=> HOST_RDATA_O[ST_EOP_BIT] == $past(eop_cnt_reg != '0))
		else $error("end-of-packet bit wrong");

	// Judged on the read data, so the status word path is covered too
	thr_equal_a: assert property (
		HOST_RD_I && rd_addr == OFS_STATE && !IS_STATIC && count == thr_reg
		|=> !HOST_RDATA_O[ST_ABOVE_BIT] && !HOST_RDATA_O[ST_BELOW_BIT])
		else $error("equal count flagged");

	static_mask_a: assert property (
		HOST_RD_I && rd_addr == OFS_STATE && IS_STATIC
		|=> HOST_RDATA_O[ST_PMASK_BIT-1:0] == '0)
		else $error("static status not masked");

	rd_mode_hold_a: assert property (
		(dma_rd_reg && !wr_dma) [*2] |-> dma_rd_reg [*2])
		else $error("read mode dropped");

	wr_mode_clear_a: assert property (
		dma_wr_on_s ##0 dma_read_s |=> !dma_wr_reg)
		else $error("write mode not cleared");

	// A steered read must return the target register, not the bus offset
	dma_steer_a: assert property (
		dma_rd_reg && HOST_RD_I && dma_addr_reg == OFS_PTRS
		|=> HOST_RDATA_O[PTR_FIRST_LSB +: PTR_W] == $past(first_reg))
		else $error("read not steered");

	done_flag_a: assert property (
		HOST_RD_I && rd_addr == OFS_RX_PKT
		|=> HOST_RDATA_O[RXP_DONE_BIT] == $past(eop_present))
		else $error("done flag wrong");

endmodule : qha_queue_regs

// ==== test/qha_host_model.sv ====
// Host processor model that drives the queue register strobes
`timescale 1ns/1ps

module qha_host_model
	import qha_pkg::*;
(
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	input wire logic rvalid_i,
	output logic [9:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [31:0] wdata_o,
	output logic eop_o
);
	initial begin
		addr_o = 10'h3ff;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 32'h0;
		eop_o = 1'b0;
	end

	// =====
	// Bus cycles
	// Burst of n writes on consecutive edges, data counting up from d
	task automatic wr(input logic [9:0] a, input logic [31:0] d,
		input int n = 1, input logic e = 1'b0);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			addr_o <= a;
			wdata_o <= d + i;
			eop_o <= e;
			wr_o <= 1'b1;
		end
		@(posedge clk_i);
		wr_o <= 1'b0;
		// Idle lines carry junk so a stale value cannot pass
		addr_o <= ~a;
		wdata_o <= ~wdata_o;
		eop_o <= ~e;
	endtask : wr

	task automatic rd(input logic [9:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		// Answer is registered, so it is taken at the following edge
		@(posedge clk_i);
		d = rvalid_i ? rdata_i : 32'hdead_beef;
	endtask : rd

	// Packet status is read ahead of every data pop
	task automatic pop(output logic [31:0] st, output logic [31:0] d);
		rd(OFS_RX_PKT, st);
		rd(OFS_RX_DATA, d);
	endtask : pop
endmodule : qha_host_model

// ==== test/queue_host_access_regs_tb.sv ====
// Self-checking bench for the queue host access registers
`timescale 1ns/1ps

module queue_host_access_regs_tb;
	import qha_pkg::*;
	logic clk;
	logic rstn;
	logic pause;
	logic [9:0] addr;
	logic wr_s;
	logic rd_s;
	logic [31:0] wdata;
	logic eop;
	logic [31:0] rdata;
	logic [31:0] rs;
	logic rvalid;
	logic txr;
	logic rdy;
	logic rdy_s;
	logic dmr;
	logic dmw;
	logic [31:0] q;
	logic [31:0] st;
	int err_total = 0;
	int samples_checked = 0;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	qha_host_model qha_host_model_i (.clk_i(clk), .rdata_i(rdata),
		.rvalid_i(rvalid), .addr_o(addr), .wr_o(wr_s), .rd_o(rd_s),
		.wdata_o(wdata), .eop_o(eop));

	qha_queue_regs qha_queue_regs_i (.CLOCK_I(clk), .RSTN_I(rstn),
		.HOST_ADDR_I(addr), .HOST_WR_I(wr_s), .HOST_RD_I(rd_s),
		.HOST_WDATA_I(wdata), .HOST_EOP_I(eop), .PAUSE_I(pause),
		.HOST_RDATA_O(rdata), .HOST_RVALID_O(rvalid), .TX_READY_O(txr),
		.QUEUE_READY_O(rdy), .DMA_READ_MODE_O(dmr),
		.DMA_WRITE_MODE_O(dmw));

	// Static queue shares the bus; only its reset view is judged
	qha_queue_regs #(.QUEUE_NUM(STATIC_Q_A)) qha_queue_regs_static_i (
		.CLOCK_I(clk), .RSTN_I(rstn), .HOST_ADDR_I(addr),
		.HOST_WR_I(wr_s), .HOST_RD_I(rd_s), .HOST_WDATA_I(wdata),
		.HOST_EOP_I(eop), .PAUSE_I(pause), .HOST_RDATA_O(rs),
		.HOST_RVALID_O(), .TX_READY_O(), .QUEUE_READY_O(rdy_s),
		.DMA_READ_MODE_O(), .DMA_WRITE_MODE_O());

	// =====
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
		qha_host_model_i.rd(a, q);
		check(q, exp);
	endtask : rchk

	task automatic wr(input logic [9:0] a, input logic [31:0] d,
		input int n = 1, input logic e = 1'b0);
		qha_host_model_i.wr(a, d, n, e);
	endtask : wr

	task automatic final_report();
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	initial begin
		#200us;
		err_total++;
		final_report();
	end

	// =====
	// Tests
	initial begin
		rstn = 1'b0;
		pause = 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		wr(10'h3f0, 32'hffff_ffff);
		rchk(OFS_PTRS, 32'h0);
		check({31'h0, txr}, 32'h1);
		check(rs, {9'h0, STATIC_A_LAST, 9'h0, STATIC_A_FIRST});
		rchk(OFS_STATE, 32'h0);
		check(rs, 32'h8000_0000);
		check({31'h0, rdy_s}, 32'h1);
		rchk(OFS_DMA, 32'h0);
		rchk(OFS_RX_PKT, 32'h0);
		rchk(OFS_TX_DATA, 32'h0);
		rchk(10'h3f0, 32'h0);
		wr(OFS_PTRS, 32'hffff_ffff);
		rchk(OFS_PTRS, 32'h007f_007f);
		// Threshold 2, mode above, mask clear
		// Old mode still sees a nonzero first pointer, so the set wins
		wr(OFS_STATE, 32'h0100_0200);
		rchk(OFS_STATE, 32'h8101_0200);
		wr(OFS_PTRS, 32'h0);
		wr(OFS_STATE, 32'h0100_0200);
		rchk(OFS_STATE, 32'h0101_0200);
		wr(OFS_TX_DATA, 32'ha000_0000);
		wr(OFS_TX_DATA, 32'ha000_0001, 1, 1'b1);
		rchk(OFS_STATE, 32'h0104_0202);
		@(posedge clk) pause <= 1'b1;
		wr(OFS_TX_DATA, 32'ha000_0002);
		rchk(OFS_STATE, 32'h0106_0203);
		wr(OFS_STATE, 32'h4100_0200);
		rchk(OFS_STATE, 32'hc106_0203);
		check({31'h0, rdy}, 32'h1);
		wr(OFS_PTRS, 32'h0);
		// Mask cleared first, or the first pass could not clear the flag
		wr(OFS_STATE, 32'h0);
		// Pause held over each write so the sticky flag really clears
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) pause <= 1'b1;
			wr(OFS_STATE, {6'h0, i[1:0], 9'h0, (i[2] ? 7'd1 : 7'd5), 8'h0});
			@(posedge clk) pause <= 1'b0;
			repeat (2) @(posedge clk);
			#1;
			check({31'h0, rdy}, {31'h0, (i[1:0] == 2'd1 && i[2]) || i[1]});
		end
		for (int i = 0; i < 3; i++) begin
			qha_host_model_i.pop(st, q);
			check(st, (i < 2) ? 32'h8000_0000 : 32'h0);
			check(q, 32'ha000_0000 + i);
		end
		rchk(OFS_RX_DATA, 32'h0);
		// Seventeenth word meets a full queue and is dropped
		wr(OFS_TX_DATA, 32'hb000_0000, 17);
		check({31'h0, txr}, 32'h0);
		qha_host_model_i.rd(OFS_STATE, q);
		check(q & 32'h7f, 32'h10);
		for (int i = 0; i < 16; i++) begin
			qha_host_model_i.pop(st, q);
			check(q, 32'hb000_0000 + i);
		end
		rchk(OFS_RX_DATA, 32'h0);
		wr(OFS_PTRS, 32'h0011_0022);
		wr(OFS_DMA, 32'h0002_0018);
		@(negedge clk);
		check({31'h0, dmr}, 32'h1);
		rchk(OFS_TX_DATA, 32'h0011_0022);
		rchk(OFS_DMA, 32'h0011_0022);
		wr(OFS_DMA, 32'h0001_0018);
		@(negedge clk);
		check({30'h0, dmr, dmw}, 32'h1);
		wr(OFS_TX_DATA, 32'h0055_0033);
		rchk(OFS_DMA, 32'h0001_0018);
		check({31'h0, dmw}, 32'h0);
		rchk(OFS_PTRS, 32'h0055_0033);
		rchk(OFS_RX_DATA, 32'h0);
		final_report();
	end
endmodule : queue_host_access_regs_tb
